// File: inc/uatw_defs.svh
// Offsets, field positions, reset values and fixed codes of the translation window registers
`ifndef UATW_DEFS_SVH
`define UATW_DEFS_SVH
`define UATW_AW 8
`define UATW_OFF_BASE0 8'he0
`define UATW_OFF_SETUP0 8'he4
`define UATW_OFF_BASE1 8'he8
`define UATW_OFF_SETUP1 8'hec
`define UATW_OFF_CAP 8'hf0
`define UATW_KEEP0 32'hfffff000
`define UATW_KEEP1 32'hffffffc0
`define UATW_TOP_BIT 32'h80000000
`define UATW_EN_BIT 31
`define UATW_PF_BIT 3
`define UATW_AT_HI 2
`define UATW_AT_LO 1
`define UATW_TS_BIT 0
`define UATW_TS_MEM 1'h0
`define UATW_AT_32 2'h0
`define UATW_AT_64 2'h1
`define UATW_CAP_ID 8'h05
`define UATW_CAP_NEXT 8'h00
`define UATW_RST_BASE 32'h00000000
`define UATW_RST_MASK 31'h00000000
`define UATW_RST_EN0 1'h1
`define UATW_RST_EN1 1'h0
`define UATW_RST_PF 1'h0
`endif

// File: inc/uatw_pkg.sv
// Types shared by the upstream translation window register bank
package uatw_pkg;
    // One window's setup fields as loaded over the secondary path
    typedef struct packed {
        logic en;
        logic [30:0] mask;
        logic pf;
        logic [1:0] atype;
    } uatw_setup_t;
    // Secondary load of a setup register
    typedef struct packed {
        logic wr;
        logic win;
        logic [31:0] data;
    } uatw_load_t;
    // Upstream request that already hit one of the two windows
    typedef struct packed {
        logic valid;
        logic win;
        logic [31:0] addr;
    } uatw_req_t;
    // Translated request
    typedef struct packed {
        logic valid;
        logic hit;
        logic [31:0] addr;
    } uatw_xl_t;
endpackage : uatw_pkg

// File: logic/uatw_regs.sv
// Upstream translation window registers, capability id byte and address substitution
// Function
// - Window 0 base holds bits 31:12 writable, 11:0 read zero, resets zero.
// - Window 0 translation uses base bit 31 and the base bits its size mask selects.
// - Window 1 base holds bits 31:6 writable, 5:0 read zero, resets zero.
// - Window 1 translation uses base bit 31 and the base bits its size mask selects.
// - Setup bit 0 reads zero, meaning memory space, in both windows.
// - Setup bits 2:1 give address type, 00 is 32-bit, 01 64-bit, reset 00.
// - Size mask bit one makes matching base bit writable, else read-only; resets zero.
// - Window 0 enable resets one and stays one; sizing returns ones only in bit 31 and the base bits its size mask makes writable.
// - Window 1 enable bit 31 gates the window and resets to zero.
// - Offset F0 byte 0 reads fixed capability id 05h.
// - Offset F0 byte 1 reads 00h, ending the capability chain.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "uatw_defs.svh"
module uatw_regs
    import uatw_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [`UATW_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire uatw_load_t sl_load,
    input wire uatw_req_t up_req,
    output uatw_xl_t up_xl
);
    // Whole block state
    typedef struct packed {
        logic [31:0] base0;
        logic [31:0] base1;
        uatw_setup_t set0;
        uatw_setup_t set1;
        logic [31:0] rdata;
        uatw_xl_t xl;
    } uatw_state_t;

    uatw_state_t st_reg;
    uatw_state_t st_next;
    logic [31:0] eff0;
    logic [31:0] eff1;
    logic [31:0] sel_base;
    logic [31:0] sel_mask;
    logic [31:0] sub_addr;

    // Base bits that belong to the window; the top bit is always part of the base
    function automatic logic [31:0] eff_mask(input uatw_setup_t s, input logic [31:0] keep);
        eff_mask = ({1'b0, s.mask} | `UATW_TOP_BIT) & keep;
    endfunction : eff_mask

    // Setup register as software reads it
    function automatic logic [31:0] setup_word(input uatw_setup_t s, input logic [31:0] keep);
        logic [31:0] w;
        w = {s.en, s.mask & keep[30:0]};
        w[`UATW_PF_BIT] = s.pf;
        w[`UATW_AT_HI:`UATW_AT_LO] = s.atype;
        w[`UATW_TS_BIT] = `UATW_TS_MEM;
        setup_word = w;
    endfunction : setup_word

    // Secondary load of setup fields; a stuck enable ignores a written zero
    function automatic uatw_setup_t load_setup(input logic [31:0] d, input logic [31:0] keep,
                                               input logic stuck_en);
        uatw_setup_t s;
        s.mask = d[30:0] & keep[30:0];
        s.pf = d[`UATW_PF_BIT];
        s.atype = {1'b0, d[`UATW_AT_LO]};
        s.en = stuck_en | d[`UATW_EN_BIT];
        load_setup = s;
    endfunction : load_setup

    // Effective masks of both windows
    assign eff0 = eff_mask(st_reg.set0, `UATW_KEEP0);
    assign eff1 = eff_mask(st_reg.set1, `UATW_KEEP1);

    // One substitution path shared by both windows, chosen by the request
    assign sel_base = up_req.win ? st_reg.base1 : st_reg.base0;
    assign sel_mask = up_req.win ? eff1 : eff0;

    uatw_xlate u_xlate (
        .base(sel_base),
        .eff_mask(sel_mask),
        .addr_in(up_req.addr),
        .addr_out(sub_addr)
    );

    // Next state: register writes, secondary loads, read capture and translation
    always_comb begin
        st_next = st_reg;
        st_next.rdata = '0;
        // Base writes keep only bits the mask makes writable
        if (reg_wr) begin
            case (reg_addr)
                `UATW_OFF_BASE0: begin
                    st_next.base0 = reg_wdata & eff0;
                end
                `UATW_OFF_BASE1: begin
                    st_next.base1 = reg_wdata & eff1;
                end
                default: begin
                    st_next.base0 = st_reg.base0; // Setup and id are read-only here
                end
            endcase
        end
        // Only the secondary path changes the setup fields
        if (sl_load.wr) begin
            if (sl_load.win) begin
                st_next.set1 = load_setup(sl_load.data, `UATW_KEEP1, 1'b0);
            end else begin
                st_next.set0 = load_setup(sl_load.data, `UATW_KEEP0, 1'b1);
            end
        end
        // Read data stand for one cycle only; unmapped offsets read zero
        if (reg_rd) begin
            case (reg_addr)
                `UATW_OFF_BASE0: begin
                    st_next.rdata = st_reg.base0 & eff0;
                end
                `UATW_OFF_SETUP0: begin
                    st_next.rdata = setup_word(st_reg.set0, `UATW_KEEP0);
                end
                `UATW_OFF_BASE1: begin
                    st_next.rdata = st_reg.base1 & eff1;
                end
                `UATW_OFF_SETUP1: begin
                    st_next.rdata = setup_word(st_reg.set1, `UATW_KEEP1);
                end
                `UATW_OFF_CAP: begin
                    st_next.rdata = {16'h0000, `UATW_CAP_NEXT, `UATW_CAP_ID};
                end
                default: begin
                    st_next.rdata = '0;
                end
            endcase
        end
        // A disabled window passes the address untouched
        st_next.xl.valid = up_req.valid;
        st_next.xl.hit = up_req.valid & (up_req.win ? st_reg.set1.en : st_reg.set0.en);
        st_next.xl.addr = st_next.xl.hit ? sub_addr : up_req.addr;
    end

    // State register; reset gives empty bases, window 0 enabled, window 1 off
    // Reset is synchronous, so a reset pulse must span at least one clock edge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_reg.base0 <= `UATW_RST_BASE;
            st_reg.base1 <= `UATW_RST_BASE;
            st_reg.set0.en <= `UATW_RST_EN0;
            st_reg.set0.mask <= `UATW_RST_MASK;
            st_reg.set0.pf <= `UATW_RST_PF;
            st_reg.set0.atype <= `UATW_AT_32;
            st_reg.set1.en <= `UATW_RST_EN1;
            st_reg.set1.mask <= `UATW_RST_MASK;
            st_reg.set1.pf <= `UATW_RST_PF;
            st_reg.set1.atype <= `UATW_AT_32;
            st_reg.rdata <= '0;
            st_reg.xl <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops
    assign reg_rdata = st_reg.rdata;
    assign up_xl = st_reg.xl;

    // Checks on the block's own behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // Helper copies of the request's window view, used only by the checks
    logic [31:0] chk_mask;
    logic [31:0] chk_base;
    assign chk_mask = sel_mask;
    assign chk_base = sel_base;

    base0_low_a: assert property (
        reg_rd && reg_addr == `UATW_OFF_BASE0 |=> (reg_rdata & ~`UATW_KEEP0) == 32'h00000000)
        else $error("window 0 base low bits not zero");

    base1_low_a: assert property (
        reg_rd && reg_addr == `UATW_OFF_BASE1 |=> (reg_rdata & ~`UATW_KEEP1) == 32'h00000000)
        else $error("window 1 base low bits not zero");

    base_write_a: assert property (
        reg_wr && reg_addr == `UATW_OFF_BASE1 && !reg_rd
        |=> st_reg.base1 == ($past(reg_wdata) & $past(eff1)))
        else $error("window 1 base write ignores size mask");

    type_sel_a: assert property (
        reg_rd && (reg_addr == `UATW_OFF_SETUP0 || reg_addr == `UATW_OFF_SETUP1)
        |=> reg_rdata[`UATW_TS_BIT] == `UATW_TS_MEM)
        else $error("setup type selector not memory");

    addr_type_a: assert property (
        st_reg.set0.atype[1] == 1'b0 && st_reg.set1.atype[1] == 1'b0)
        else $error("address type outside 32 or 64 bit");

    sizing_read_a: assert property (
        reg_wr && reg_addr == `UATW_OFF_BASE0 && reg_wdata == 32'hffffffff && !sl_load.wr
        && eff0 == `UATW_KEEP0 ##1 reg_rd && reg_addr == `UATW_OFF_BASE0
        |=> reg_rdata == `UATW_KEEP0)
        else $error("window 0 sizing does not return all ones");

    w0_enable_a: assert property (
        st_reg.set0.en == 1'b1)
        else $error("window 0 enable dropped");

    reset_vals_a: assert property (
        $fell(srst) |-> !st_reg.set1.en && !st_reg.set0.pf && !st_reg.set1.pf && st_reg.base1 == '0)
        else $error("reset values wrong");

    cap_id_a: assert property (
        reg_rd && reg_addr == `UATW_OFF_CAP |=> reg_rdata[15:0] == {`UATW_CAP_NEXT, `UATW_CAP_ID})
        else $error("capability id or next pointer wrong");

    setup_ro_a: assert property (
        !sl_load.wr |=> $stable(st_reg.set0) && $stable(st_reg.set1))
        else $error("setup changed without secondary load");

    xlate_hit_a: assert property (
        up_req.valid && (up_req.win ? st_reg.set1.en : st_reg.set0.en)
        |=> up_xl.hit && (up_xl.addr & $past(chk_mask)) == ($past(chk_base) & $past(chk_mask))
        && (up_xl.addr & ~$past(chk_mask)) == ($past(up_req.addr) & ~$past(chk_mask)))
        else $error("translated address wrong");

    xlate_off_a: assert property (
        up_req.valid && up_req.win && !st_reg.set1.en |=> !up_xl.hit && up_xl.addr == $past(up_req.addr))
        else $error("disabled window 1 translated");

    rd_once_a: assert property (
        !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data held past one cycle");

    // Reset values as seen at the first edge out of reset
    reset_out_a: assert property (
        $fell(srst) |-> reg_rdata == 32'h00000000 && up_xl == '0 && st_reg.base0 == '0
        && st_reg.set0.en && st_reg.set0.mask == '0 && st_reg.set1.mask == '0)
        else $error("outputs or window 0 not at reset values");

    // Register view of the window 0 base, the setup words and the unmapped offsets
    base0_write_a: assert property (
        reg_wr && reg_addr == `UATW_OFF_BASE0
        |=> st_reg.base0 == ($past(reg_wdata) & $past(eff0)))
        else $error("window 0 base write ignores size mask");

    addr_type_rd_a: assert property (
        reg_rd && (reg_addr == `UATW_OFF_SETUP0 || reg_addr == `UATW_OFF_SETUP1)
        |=> reg_rdata[`UATW_AT_HI] == 1'b0)
        else $error("setup address type reads a reserved code");

    w0_en_rd_a: assert property (
        reg_rd && reg_addr == `UATW_OFF_SETUP0 |=> reg_rdata[`UATW_EN_BIT] == 1'b1)
        else $error("window 0 enable reads zero");

    w1_en_rd_a: assert property (
        reg_rd && reg_addr == `UATW_OFF_SETUP1 |=> reg_rdata[`UATW_EN_BIT] == $past(st_reg.set1.en))
        else $error("window 1 enable reads wrong");

    pf_rd_a: assert property (
        reg_rd && reg_addr == `UATW_OFF_SETUP0 |=> reg_rdata[`UATW_PF_BIT] == $past(st_reg.set0.pf))
        else $error("window 0 prefetch flag reads wrong");

    unmapped_rd_a: assert property (
        reg_rd && reg_addr > `UATW_OFF_CAP |=> reg_rdata == 32'h00000000)
        else $error("unmapped offset reads nonzero");

    // Secondary load path; a load must be visible at the very next edge
    load_w1_a: assert property (
        sl_load.wr && sl_load.win
        |=> st_reg.set1.en == $past(sl_load.data[`UATW_EN_BIT])
        && {1'b0, st_reg.set1.mask} == ($past(sl_load.data) & `UATW_KEEP1 & ~`UATW_TOP_BIT))
        else $error("window 1 setup load not taken");

    load_w0_a: assert property (
        sl_load.wr && !sl_load.win
        |=> st_reg.set0.pf == $past(sl_load.data[`UATW_PF_BIT])
        && st_reg.set0.atype == {1'b0, $past(sl_load.data[`UATW_AT_LO])})
        else $error("window 0 setup load not taken");

    // Translation path: every request gets one answer, window 0 always hits
    xlate_valid_a: assert property (
        up_req.valid |=> up_xl.valid)
        else $error("translation result dropped");

    w0_hit_a: assert property (
        up_req.valid && !up_req.win |=> up_xl.hit)
        else $error("window 0 request missed");

    // Main scenarios the bench is expected to reach
    cov_w1_enable_c: cover property (sl_load.wr && sl_load.win && sl_load.data[`UATW_EN_BIT]);
    cov_w1_hit_c: cover property (up_req.valid && up_req.win ##1 up_xl.hit);
    cov_w0_hit_c: cover property (up_req.valid && !up_req.win ##1 up_xl.hit);
    cov_cap_rd_c: cover property (reg_rd && reg_addr == `UATW_OFF_CAP);
    cov_sizing_c: cover property (reg_wr && reg_addr == `UATW_OFF_BASE0 && eff0 == `UATW_KEEP0);
endmodule : uatw_regs

// File: logic/uatw_xlate.sv
// Address substitution for one window: base bits where masked, offset bits elsewhere
`timescale 1ns/1ps
module uatw_xlate
    import uatw_pkg::*;
(
    input wire logic [31:0] base,
    input wire logic [31:0] eff_mask,
    input wire logic [31:0] addr_in,
    output logic [31:0] addr_out
);
    // Only base bits inside the effective mask replace the incoming address
    assign addr_out = (base & eff_mask) | (addr_in & ~eff_mask);
endmodule : uatw_xlate

// File: tb/tb_upstream_addr_translation_windows.sv
// Self-checking testbench for the upstream translation window register bank
`timescale 1ns/1ps
`include "uatw_defs.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_upstream_addr_translation_windows
    import uatw_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [`UATW_AW-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, er;
    logic reg_wr, reg_rd;
    logic rd_d = 1'b0;
    uatw_load_t sl_load;
    uatw_req_t up_req;
    uatw_xl_t up_xl, ex;
    logic [31:0] rq [$];
    uatw_xl_t xq [$];
    logic [31:0] base [2];
    logic [31:0] su [2];
    logic [31:0] keep [2] = '{`UATW_KEEP0, `UATW_KEEP1};
    logic [7:0] offs [7] = '{8'he0, 8'he4, 8'he8, 8'hec, 8'hf0, 8'hf4, 8'h00};
    int num_errors = 0;
    int compares = 0;

    always #2.5 ref_clk = ~ref_clk;

    uatw_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
                    .reg_rd(reg_rd), .sl_load(sl_load), .up_req(up_req));
    uatw_regs DUT (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
                   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sl_load(sl_load), .up_req(up_req), .up_xl(up_xl));

    // Effective mask: bit 31 always part of the base, low offset bits never
    function automatic logic [31:0] em(input logic w);
        return {1'b1, su[w][30:0]} & keep[w];
    endfunction : em

    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            `UATW_OFF_BASE0: return base[0] & em(1'b0);
            `UATW_OFF_SETUP0: return su[0];
            `UATW_OFF_BASE1: return base[1] & em(1'b1);
            `UATW_OFF_SETUP1: return su[1];
            `UATW_OFF_CAP: return {16'h0000, `UATW_CAP_NEXT, `UATW_CAP_ID};
            default: return 32'h00000000;
        endcase
    endfunction : exp_rd

    task automatic mreset();
        base = '{32'h00000000, 32'h00000000};
        su = '{`UATW_TOP_BIT, 32'h00000000};
    endtask : mreset

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.drv(1'b1, 1'b0, a, d, '0, '0);
        if (a == `UATW_OFF_BASE0) base[0] = d & em(1'b0);
        if (a == `UATW_OFF_BASE1) base[1] = d & em(1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        rq.push_back(exp_rd(a));
        host.drv(1'b0, 1'b1, a, '0, '0, '0);
    endtask : rd

    // Enable, pf, atype bit 0 and mask survive; window 0 enable is forced on
    task automatic ld(input logic w, input logic [31:0] d);
        logic [31:0] s;
        host.load(w, d, s);
        su[w] = w ? (s & 32'hffffffca) : ((s & 32'h7ffff00a) | `UATW_TOP_BIT);
    endtask : ld

    task automatic xl(input logic w, input logic [31:0] a);
        logic [31:0] m;
        uatw_xl_t x;
        m = em(w);
        x = su[w][31] ? {1'b1, 1'b1, (base[w] & m) | (a & ~m)} : {1'b1, 1'b0, a};
        xq.push_back(x);
        host.drv(1'b0, 1'b0, '0, '0, '0, {1'b1, w, a});
    endtask : xl

    task automatic end_of_test();
        num_errors += rq.size() + xq.size();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // Results appear one cycle after the request; compare mid-cycle when settled
    always @(posedge ref_clk) rd_d <= reg_rd & ~srst;
    always @(negedge ref_clk) begin
        if (rd_d === 1'b1) begin
            er = rq.pop_front();
            `CHK("reg_rdata", er, reg_rdata)
        end
        if (up_xl.valid === 1'b1) begin
            ex = xq.pop_front();
            `CHK("up_xl", ex, up_xl)
        end
    end

    // Reset sequence, mapping checks, setup loads and random translations
    initial begin
        void'($urandom(32'he6244bcc));
        mreset();
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        foreach (offs[i]) rd(offs[i]);
        wr(`UATW_OFF_BASE0, 32'hffffffff);
        rd(`UATW_OFF_BASE0);
        wr(`UATW_OFF_SETUP0, 32'h00000000);
        wr(`UATW_OFF_SETUP1, 32'hffffffff);
        wr(`UATW_OFF_CAP, 32'hffffffff);
        foreach (offs[i]) rd(offs[i]);
        xl(1'b1, $urandom);
        xl(1'b0, $urandom);
        ld(1'b0, 32'h00000000);
        ld(1'b1, 32'hffffffff);
        rd(`UATW_OFF_SETUP0);
        rd(`UATW_OFF_SETUP1);
        // Full window 0 mask: sizing with all ones reads back the whole base field
        ld(1'b0, 32'hffffffff);
        wr(`UATW_OFF_BASE0, 32'hffffffff);
        rd(`UATW_OFF_BASE0);
        // Random masks and bases exercise random window sizes and both window 1 enable states
        for (int i = 0; i < 40; i++) begin
            ld(i[0], $urandom);
            wr(i[0] ? `UATW_OFF_BASE1 : `UATW_OFF_BASE0, $urandom);
            rd(i[0] ? `UATW_OFF_BASE1 : `UATW_OFF_BASE0);
            rd(i[0] ? `UATW_OFF_SETUP1 : `UATW_OFF_SETUP0);
            xl(1'b0, $urandom);
            xl(1'b1, $urandom);
        end
        host.drv(1'b0, 1'b0, '0, '0, '0, '0);
        // Second reset in mid-run must bring back every reset value
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        mreset();
        @(posedge ref_clk);
        foreach (offs[i]) rd(offs[i]);
        host.drv(1'b0, 1'b0, '0, '0, '0, '0);
        repeat (3) @(posedge ref_clk);
        end_of_test();
    end

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        end_of_test();
    end
endmodule : tb_upstream_addr_translation_windows

// File: tb/uatw_host.sv
// Host-side model issuing register accesses, setup loads and upstream requests
`timescale 1ns/1ps
`include "uatw_defs.svh"
module uatw_host
    import uatw_pkg::*;
(
    input wire logic ref_clk,
    output logic [`UATW_AW-1:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output uatw_load_t sl_load,
    output uatw_req_t up_req
);
    // Idle at time zero so nothing is taken while reset is held
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sl_load = '0;
        up_req = '0;
    end

    // One cycle: all inputs set after an edge and held until the next edge takes them
    task automatic drv(input logic w, input logic r, input logic [`UATW_AW-1:0] a, input logic [31:0] d,
                       input uatw_load_t l, input uatw_req_t q);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        sl_load <= l;
        up_req <= q;
        @(posedge ref_clk);
    endtask : drv

    // Window 1 is always memory space, so the host keeps its mask bits 11:6 clear
    task automatic load(input logic w, input logic [31:0] d, output logic [31:0] s);
        s = w ? (d & ~32'h00000fc0) : d;
        drv(1'b0, 1'b0, '0, '0, {1'b1, w, s}, '0);
    endtask : load
endmodule : uatw_host
